// *** src/vfg_top.sv ***
`timescale 1ns/10ps
`default_nettype none

module vfg_top
(
   input  wire logic        pclk,                     // core clock, 10 MHz
   input  wire logic        presetn,                  // async reset, active low
   input  wire logic        psel,                     // apb select
   input  wire logic        penable,                  // apb access phase
   input  wire logic        pwrite,                   // apb direction
   input  wire logic [7:0]  paddr,                    // apb byte address
   input  wire logic [31:0] pwdata,                   // apb write data
   output logic      [31:0] prdata,                   // apb read data
   output logic             pready,                   // apb ready
   output logic             pslverr,                  // apb error, unmapped address
   input  wire logic        ignore_numeric_error_pin, // legacy pin, has no effect here
   input  wire logic        hw_task_switch,           // native task switch pulse
   output logic             vector_fp_fault,          // one-cycle fault pulse
   output logic             undefined_opcode_fault,   // one-cycle fault pulse
   output logic             device_unavailable_fault  // one-cycle fault pulse
);

   // apb group
   logic        pready_reg;
   logic        pready_next;
   logic        pslverr_reg;
   logic        pslverr_next;
   logic [31:0] prdata_reg;
   logic [31:0] prdata_next;

   // core group
   logic        em_reg;
   logic        em_next;
   logic        ts_reg;
   logic        ts_next;
   logic        ne_reg;
   logic        ne_next;
   logic        osh_reg;
   logic        osh_next;
   logic [5:0]  mask_reg;
   logic [5:0]  mask_next;
   logic [5:0]  flag_reg;
   logic [5:0]  flag_next;
   logic [31:0] operand_reg;
   logic [31:0] operand_next;
   logic [31:0] scalar_reg;
   logic [31:0] scalar_next;
   logic [31:0] vdata_reg  [vfg_pkg::NUM_VREGS];
   logic [31:0] vdata_next [vfg_pkg::NUM_VREGS];
   logic [31:0] image_reg  [vfg_pkg::IMAGE_WORDS];
   logic [31:0] image_next [vfg_pkg::IMAGE_WORDS];
   logic [1:0]  last_fault_reg;
   logic [1:0]  last_fault_next;
   logic [7:0]  exec_cnt_reg;
   logic [7:0]  exec_cnt_next;
   logic        xf_reg;
   logic        xf_next;
   logic        ud_reg;
   logic        ud_next;
   logic        nm_reg;
   logic        nm_next;

   // decode
   logic        wr_fire;
   logic        addr_vdata;
   logic        addr_image;
   logic        mapped;
   logic [2:0]  vidx;
   logic [3:0]  iidx;
   logic        issue_fire;
   logic [2:0]  iss_cls;
   logic [5:0]  iss_cond;
   logic [2:0]  iss_dest;
   logic [31:0] ctrl_view;
   logic [31:0] vcsr_view;

   // checks
   logic        gate_ud;
   logic        gate_nm;
   logic [5:0]  num_detected;
   logic        num_xf;
   logic        num_ud;
   logic        num_default;
   logic        gated;
   logic        executes;

   vfg_gate u_gate
   (
      .cls (iss_cls),
      .em  (em_reg),
      .ts  (ts_reg),
      .ud  (gate_ud),
      .nm  (gate_nm)
   );

   vfg_numeric u_numeric
   (
      .cls         (iss_cls),
      .cond        (iss_cond),
      .mask        (mask_reg),
      .osh         (osh_reg),
      .detected    (num_detected),
      .xf          (num_xf),
      .ud          (num_ud),
      .use_default (num_default)
   );

   always_comb
   begin
      wr_fire    = psel && penable && pready_reg && pwrite;
      addr_vdata = (paddr[7:5] == vfg_pkg::ADDR_VDATA[7:5]);
      addr_image = (paddr[7] == 1'b1) && (paddr[6:2] < 5'(vfg_pkg::IMAGE_WORDS));
      vidx       = paddr[4:2];
      iidx       = paddr[5:2];
      mapped     = (paddr[1:0] == 2'h0) &&
                   ((paddr <= vfg_pkg::ADDR_SCALAR) || addr_vdata || addr_image);
      issue_fire = wr_fire && (paddr == vfg_pkg::ADDR_ISSUE);
      iss_cls    = pwdata[vfg_pkg::ISSUE_CLASS_LSB +: 3];
      iss_cond   = pwdata[vfg_pkg::ISSUE_COND_LSB +: vfg_pkg::NUM_COND];
      iss_dest   = pwdata[vfg_pkg::ISSUE_DEST_LSB +: 3];
      ctrl_view  = 32'h00000000;
      ctrl_view[vfg_pkg::CTRL_EM_BIT]  = em_reg;
      ctrl_view[vfg_pkg::CTRL_TS_BIT]  = ts_reg;
      ctrl_view[vfg_pkg::CTRL_NE_BIT]  = ne_reg;
      ctrl_view[vfg_pkg::CTRL_OSH_BIT] = osh_reg;
      vcsr_view  = 32'h00000000;
      vcsr_view[vfg_pkg::VCSR_FLAG_LSB +: vfg_pkg::NUM_COND] = flag_reg;
      vcsr_view[vfg_pkg::VCSR_MASK_LSB +: vfg_pkg::NUM_COND] = mask_reg;
      // gate faults stop the instruction before it touches anything
      gated      = gate_ud || gate_nm;
      executes   = issue_fire && !gated;
   end

   // apb slave: ready one cycle after setup, so every access has no wait state
   always_comb
   begin
      pready_next  = psel && !penable;
      pslverr_next = psel && !penable && !mapped;
      prdata_next  = 32'h00000000;
      if (psel && !penable && !pwrite && mapped)
      begin
         if (addr_vdata)
            prdata_next = vdata_reg[vidx];
         else if (addr_image)
            prdata_next = image_reg[iidx];
         else
         begin
            case (paddr)
               vfg_pkg::ADDR_CTRL:    prdata_next = ctrl_view;
               vfg_pkg::ADDR_VCSR:    prdata_next = vcsr_view;
               vfg_pkg::ADDR_OPERAND: prdata_next = operand_reg;
               vfg_pkg::ADDR_STATUS:  prdata_next = {22'h000000, exec_cnt_reg, last_fault_reg};
               vfg_pkg::ADDR_SCALAR:  prdata_next = scalar_reg;
               default:               prdata_next = 32'h00000000;
            endcase
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= 32'h00000000;
      end
      else
      begin
         pready_reg  <= pready_next;
         pslverr_reg <= pslverr_next;
         prdata_reg  <= prdata_next;
      end
   end

   always_comb
   begin
      em_next         = em_reg;
      ts_next         = ts_reg;
      ne_next         = ne_reg;
      osh_next        = osh_reg;
      mask_next       = mask_reg;
      flag_next       = flag_reg;
      operand_next    = operand_reg;
      scalar_next     = scalar_reg;
      vdata_next      = vdata_reg;
      image_next      = image_reg;
      last_fault_next = last_fault_reg;
      exec_cnt_next   = exec_cnt_reg;
      xf_next         = 1'b0;
      ud_next         = 1'b0;
      nm_next         = 1'b0;

      if (wr_fire && !pslverr_reg)
      begin
         if (paddr == vfg_pkg::ADDR_CTRL)
         begin
            // explicit move to the control register
            em_next  = pwdata[vfg_pkg::CTRL_EM_BIT];
            ts_next  = pwdata[vfg_pkg::CTRL_TS_BIT];
            ne_next  = pwdata[vfg_pkg::CTRL_NE_BIT];  // stored, never consulted
            osh_next = pwdata[vfg_pkg::CTRL_OSH_BIT];
         end
         if (paddr == vfg_pkg::ADDR_VCSR)
         begin
            mask_next = pwdata[vfg_pkg::VCSR_MASK_LSB +: vfg_pkg::NUM_COND];
            flag_next = pwdata[vfg_pkg::VCSR_FLAG_LSB +: vfg_pkg::NUM_COND];
         end
         if (paddr == vfg_pkg::ADDR_OPERAND)
            operand_next = pwdata;
         if (paddr == vfg_pkg::ADDR_SCALAR)
            scalar_next = pwdata;
         if (addr_vdata)
            vdata_next[vidx] = pwdata;
         if (addr_image)
            image_next[iidx] = pwdata;
      end

      if (issue_fire)
      begin
         if (gate_ud)
         begin
            ud_next         = 1'b1;
            last_fault_next = vfg_pkg::VFG_FLT_UD;
         end
         else if (gate_nm)
         begin
            nm_next         = 1'b1;
            last_fault_next = vfg_pkg::VFG_FLT_NM;
         end
         else if (num_xf)
         begin
            // unmasked: fault with destination untouched, restartable
            xf_next         = 1'b1;
            last_fault_next = vfg_pkg::VFG_FLT_XF;
         end
         else if (num_ud)
         begin
            ud_next         = 1'b1;
            last_fault_next = vfg_pkg::VFG_FLT_UD;
         end
         else
            last_fault_next = vfg_pkg::VFG_FLT_NONE;
      end

      if (executes)
      begin
         exec_cnt_next = exec_cnt_reg + 8'h01;
         flag_next     = flag_next | num_detected;
         case (iss_cls)
            vfg_pkg::VFG_CLS_VEC_FP:
            begin
               if (num_default)
                  vdata_next[iss_dest] = vfg_pkg::DEFAULT_RESULT;
               else if (!num_xf && !num_ud)
                  vdata_next[iss_dest] = operand_reg;
            end
            vfg_pkg::VFG_CLS_VEC_INT:
               vdata_next[iss_dest] = operand_reg;
            vfg_pkg::VFG_CLS_SCALAR:
               scalar_next = operand_reg;
            vfg_pkg::VFG_CLS_SAVE:
            begin
               for (int i = 0; i < vfg_pkg::NUM_VREGS; i++)
                  image_next[i] = vdata_reg[i];
               image_next[vfg_pkg::IMG_VCSR]   = vcsr_view;
               image_next[vfg_pkg::IMG_SCALAR] = scalar_reg;
            end
            vfg_pkg::VFG_CLS_RESTORE:
            begin
               for (int i = 0; i < vfg_pkg::NUM_VREGS; i++)
                  vdata_next[i] = image_reg[i];
               flag_next   = image_reg[vfg_pkg::IMG_VCSR][vfg_pkg::VCSR_FLAG_LSB +: vfg_pkg::NUM_COND];
               mask_next   = image_reg[vfg_pkg::IMG_VCSR][vfg_pkg::VCSR_MASK_LSB +: vfg_pkg::NUM_COND];
               scalar_next = image_reg[vfg_pkg::IMG_SCALAR];
            end
            vfg_pkg::VFG_CLS_CLRSW:
               ts_next = 1'b0;
            default:
               ts_next = ts_next;
         endcase
      end

      // a hardware task switch wins over any clear in the same cycle
      if (hw_task_switch)
         ts_next = 1'b1;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         em_reg         <= 1'b0;
         ts_reg         <= 1'b0;
         ne_reg         <= 1'b0;
         osh_reg        <= 1'b0;
         mask_reg       <= vfg_pkg::MASK_RESET;
         flag_reg       <= 6'h00;
         operand_reg    <= 32'h00000000;
         scalar_reg     <= 32'h00000000;
         for (int i = 0; i < vfg_pkg::NUM_VREGS; i++)
            vdata_reg[i] <= 32'h00000000;
         for (int i = 0; i < vfg_pkg::IMAGE_WORDS; i++)
            image_reg[i] <= 32'h00000000;
         last_fault_reg <= 2'h0;
         exec_cnt_reg   <= 8'h00;
         xf_reg         <= 1'b0;
         ud_reg         <= 1'b0;
         nm_reg         <= 1'b0;
      end
      else
      begin
         em_reg         <= em_next;
         ts_reg         <= ts_next;
         ne_reg         <= ne_next;
         osh_reg        <= osh_next;
         mask_reg       <= mask_next;
         flag_reg       <= flag_next;
         operand_reg    <= operand_next;
         scalar_reg     <= scalar_next;
         vdata_reg      <= vdata_next;
         image_reg      <= image_next;
         last_fault_reg <= last_fault_next;
         exec_cnt_reg   <= exec_cnt_next;
         xf_reg         <= xf_next;
         ud_reg         <= ud_next;
         nm_reg         <= nm_next;
      end
   end

   assign prdata                   = prdata_reg;
   assign pready                   = pready_reg;
   assign pslverr                  = pslverr_reg;
   assign vector_fp_fault          = xf_reg;
   assign undefined_opcode_fault   = ud_reg;
   assign device_unavailable_fault = nm_reg;

endmodule

`default_nettype wire

// *** src/vfg_pkg.sv ***
package vfg_pkg;

   // register byte addresses
   localparam logic [7:0] ADDR_CTRL      = 8'h00;
   localparam logic [7:0] ADDR_VCSR      = 8'h04;
   localparam logic [7:0] ADDR_ISSUE     = 8'h08;
   localparam logic [7:0] ADDR_OPERAND   = 8'h0C;
   localparam logic [7:0] ADDR_STATUS    = 8'h10;
   localparam logic [7:0] ADDR_SCALAR    = 8'h14;
   localparam logic [7:0] ADDR_VDATA     = 8'h20;
   localparam logic [7:0] ADDR_IMAGE     = 8'h80;

   // system control register fields
   localparam int CTRL_EM_BIT  = 2;
   localparam int CTRL_TS_BIT  = 3;
   localparam int CTRL_NE_BIT  = 5;
   localparam int CTRL_OSH_BIT = 10;

   // vector control/status register fields
   localparam int VCSR_FLAG_LSB = 0;
   localparam int VCSR_MASK_LSB = 7;
   localparam int NUM_COND      = 6;
   localparam logic [5:0] MASK_RESET = 6'h00;

   // issue register fields
   localparam int ISSUE_CLASS_LSB = 0;
   localparam int ISSUE_COND_LSB  = 8;
   localparam int ISSUE_DEST_LSB  = 16;

   localparam int NUM_VREGS  = 8;
   localparam int IMAGE_WORDS = 10;
   localparam int IMG_VCSR   = 8;
   localparam int IMG_SCALAR = 9;

   localparam logic [31:0] DEFAULT_RESULT = 32'h7FC00000;

   typedef enum logic [2:0] {
      VFG_CLS_NONE    = 3'h0,
      VFG_CLS_VEC_FP  = 3'h1,
      VFG_CLS_VEC_INT = 3'h2,
      VFG_CLS_SCALAR  = 3'h3,
      VFG_CLS_SAVE    = 3'h4,
      VFG_CLS_RESTORE = 3'h5,
      VFG_CLS_CLRSW   = 3'h6,
      VFG_CLS_RSVD    = 3'h7
   } vfg_class_t;

   typedef enum logic [1:0] {
      VFG_FLT_NONE = 2'h0,
      VFG_FLT_UD   = 2'h1,
      VFG_FLT_NM   = 2'h2,
      VFG_FLT_XF   = 2'h3
   } vfg_fault_t;

endpackage

// *** src/vfg_gate.sv ***
`timescale 1ns/10ps
`default_nettype none

module vfg_gate
(
   input  wire logic [2:0] cls,          // instruction class
   input  wire logic       em,           // emulation flag
   input  wire logic       ts,           // task-switched flag
   output logic            ud,           // undefined-opcode fault
   output logic            nm            // device-unavailable fault
);

   logic is_vec;
   logic touches;

   always_comb
   begin
      is_vec  = (cls == vfg_pkg::VFG_CLS_VEC_FP) || (cls == vfg_pkg::VFG_CLS_VEC_INT);
      touches = is_vec || (cls == vfg_pkg::VFG_CLS_SCALAR) ||
                (cls == vfg_pkg::VFG_CLS_SAVE) || (cls == vfg_pkg::VFG_CLS_RESTORE);
      ud      = is_vec && em;
      nm      = touches && ts && !ud;
   end

endmodule

`default_nettype wire

// *** src/vfg_numeric.sv ***
`timescale 1ns/10ps
`default_nettype none

module vfg_numeric
(
   input  wire logic [2:0] cls,          // instruction class
   input  wire logic [5:0] cond,         // raw conditions from the datapath
   input  wire logic [5:0] mask,         // per-condition masks
   input  wire logic       osh,          // handler-present flag
   output logic      [5:0] detected,     // conditions that count
   output logic            xf,           // vector fp fault
   output logic            ud,           // undefined-opcode via missing handler
   output logic            use_default   // masked condition, write default
);

   logic unmasked;

   always_comb
   begin
      // packed integer ops never report numeric conditions
      detected    = (cls == vfg_pkg::VFG_CLS_VEC_FP) ? cond : 6'h00;
      unmasked    = |(detected & ~mask);
      xf          = unmasked && osh;
      ud          = unmasked && !osh;
      use_default = (|detected) && !unmasked;
   end

endmodule

`default_nettype wire

// *** tb/vfg_props.sv ***
`timescale 1ns/10ps
`default_nettype none

module vfg_props
(
   input wire logic        pclk,                     // clock
   input wire logic        presetn,                  // reset
   input wire logic        psel,                     // select
   input wire logic        penable,                  // access
   input wire logic        pwrite,                   // direction
   input wire logic [7:0]  paddr,                    // address
   input wire logic [31:0] pwdata,                   // write data
   input wire logic [31:0] prdata,                   // read data
   input wire logic        pready,                   // ready
   input wire logic        pslverr,                  // error
   input wire logic        ignore_numeric_error_pin, // legacy pin
   input wire logic        hw_task_switch,           // task switch
   input wire logic        vector_fp_fault,          // fault
   input wire logic        undefined_opcode_fault,   // fault
   input wire logic        device_unavailable_fault  // fault
);
   logic em_reg;
   logic em_next;
   logic ts_reg;
   logic ts_next;
   logic ctrl_wr;
   logic any_flt;

   // shadow of the gating flags, tracked from bus writes and the hw_task_switch pin
   assign ctrl_wr = psel && penable && pready && pwrite && paddr == vfg_pkg::ADDR_CTRL;
   assign any_flt = vector_fp_fault || undefined_opcode_fault || device_unavailable_fault;

   always_comb
   begin
      em_next = ctrl_wr ? pwdata[2] : em_reg;
      ts_next = ts_reg;
      if (hw_task_switch)
         ts_next = 1'b1;
      else if (ctrl_wr)
         ts_next = pwdata[3];
      else if (psel && penable && pready && pwrite && paddr == vfg_pkg::ADDR_ISSUE && pwdata[2:0] == 3'h6)
         ts_next = 1'b0;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         em_reg <= 1'b0;
         ts_reg <= 1'b0;
      end
      else
      begin
         em_reg <= em_next;
         ts_reg <= ts_next;
      end
   end

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence setup_s;
      psel && !penable;
   endsequence
   sequence issue_s;
      psel && penable && pready && pwrite && paddr == vfg_pkg::ADDR_ISSUE;
   endsequence

   ready_after_setup_a: assert property (setup_s |=> pready)
      else $error("ready missing after setup");
   ready_only_access_a: assert property (pready |-> $past(psel && !penable))
      else $error("ready without setup");
   err_with_ready_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   rdata_idle_zero_a: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside access");
   fault_exclusive_a: assert property ($onehot0({vector_fp_fault, undefined_opcode_fault, device_unavailable_fault}))
      else $error("two faults at once");
   fault_one_cycle_a: assert property (any_flt |=> !any_flt)
      else $error("fault longer than one cycle");
   fault_needs_issue_a: assert property (any_flt |-> $past(psel && penable && pready && pwrite && paddr == vfg_pkg::ADDR_ISSUE))
      else $error("fault without issue");
   int_no_numeric_a: assert property (issue_s ##0 (pwdata[2:0] == 3'h2 && !em_reg && !ts_reg) |=> !any_flt)
      else $error("packed integer op faulted");
   emul_undef_a: assert property (issue_s ##0 (em_reg && pwdata[2:0] inside {3'h1, 3'h2}) |=> undefined_opcode_fault)
      else $error("emulation flag did not give undefined opcode");
   switched_unavail_a: assert property (issue_s ##0 (ts_reg && !em_reg && pwdata[2:0] inside {[3'h1:3'h5]}) |=> device_unavailable_fault)
      else $error("task-switched flag did not give unavailable");
   xf_needs_cond_a: assert property (vector_fp_fault |-> $past(pwdata[2:0]) == 3'h1 && $past(pwdata[13:8]) != 6'h00)
      else $error("vector fault without fp condition");
endmodule

`default_nettype wire

// *** tb/vfg_top_test.sv ***
`timescale 1ns/10ps
`default_nettype none

module vfg_top_test;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        ignore_numeric_error_pin = 1'b0;
   logic        hw_task_switch = 1'b0;
   logic        vector_fp_fault;
   logic        undefined_opcode_fault;
   logic        device_unavailable_fault;
   logic [31:0] q;
   logic        e;
   int          err_total = 0;
   int          cmp_count = 0;
   int          ctrl, vcsr, scalar, cnt, last, i, k;
   int          vr[8];
   int          img[10];

   vfg_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ignore_numeric_error_pin(ignore_numeric_error_pin), .hw_task_switch(hw_task_switch),
      .vector_fp_fault(vector_fp_fault), .undefined_opcode_fault(undefined_opcode_fault),
      .device_unavailable_fault(device_unavailable_fault));

   always #50 pclk = ~pclk;

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] got);
      cmp_count++;
      if (got !== x)
      begin
         $display("CHECK FAILED %s expected %h seen %h", nm, x, got);
         err_total++;
      end
   endtask

   // request held until pready is seen high, released only after that edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      // no local limit: only the watchdog ends a hung wait
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      chk("pready wait", 32'h1, 32'(n));
   endtask

   task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk(nm, x, q);
   endtask

   task automatic issue(input int c, input int cd, input int dst, input int op);
      int f;
      int g;
      f = 0;
      g = (ctrl[2] && (c == 1 || c == 2)) || (ctrl[3] && c >= 1 && c <= 5);
      if (ctrl[2] && (c == 1 || c == 2))
         f = 1;
      else if (ctrl[3] && c >= 1 && c <= 5)
         f = 2;
      else if (c == 1 && (cd & ~((vcsr >> 7) & 63)) != 0)
         f = ctrl[10] ? 3 : 1;
      ignore_numeric_error_pin <= 1'($urandom);
      apb(1'b1, vfg_pkg::ADDR_OPERAND, 32'(op));
      apb(1'b1, vfg_pkg::ADDR_ISSUE, {13'h0, dst[2:0], 2'h0, cd[5:0], 5'h0, c[2:0]});
      @(posedge pclk);
      chk("fault pulse", 32'((1 << f) >> 1), {29'h0, vector_fp_fault, device_unavailable_fault, undefined_opcode_fault});
      // numeric faults still count and raise sticky flags, only gate faults stop both
      if (!g)
      begin
         cnt++;
         if (c == 1)
            vcsr |= cd & 63;
      end
      if (f == 0)
      begin
         if (c == 1 && cd != 0)
            vr[dst] = vfg_pkg::DEFAULT_RESULT;
         else if (c == 1 || c == 2)
            vr[dst] = op;
         else if (c == 3)
            scalar = op;
         for (k = 0; k < 8; k++)
            if (c == 4)
               img[k] = vr[k];
            else if (c == 5)
               vr[k] = img[k];
         if (c == 4)
            {img[8], img[9]} = {vcsr, scalar};
         if (c == 5)
            {vcsr, scalar} = {img[8], img[9]};
         if (c == 6)
            ctrl[3] = 0;
      end
      last = f;
      rdc("status", vfg_pkg::ADDR_STATUS, {22'h0, cnt[7:0], last[1:0]});
   endtask

   initial
   begin
      void'($urandom(68));
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      rdc("ctrl", vfg_pkg::ADDR_CTRL, 32'h0);
      rdc("vcsr", vfg_pkg::ADDR_VCSR, 32'h0);
      apb(1'b0, 8'h18, 32'h0);
      chk("unmapped err", 32'h1, {31'h0, e});
      chk("unmapped data", 32'h0, q);
      $display("test reset done");

      ctrl = 32'h400;
      apb(1'b1, vfg_pkg::ADDR_CTRL, ctrl);
      for (i = 0; i < 6; i++)
      begin
         vcsr = 32'h1F80 & ~(32'h80 << i);
         apb(1'b1, vfg_pkg::ADDR_VCSR, vcsr);
         issue(1, 1 << i, i, $urandom);
         vcsr = 32'h80 << i;
         apb(1'b1, vfg_pkg::ADDR_VCSR, vcsr);
         issue(1, 1 << i, i, $urandom);
         rdc("vreg", 8'(vfg_pkg::ADDR_VDATA + 4 * i), vr[i]);
         rdc("vcsr", vfg_pkg::ADDR_VCSR, vcsr);
         issue(2, 63, 7, $urandom);
      end
      ctrl = 0;
      apb(1'b1, vfg_pkg::ADDR_CTRL, ctrl);
      vcsr = 0;
      apb(1'b1, vfg_pkg::ADDR_VCSR, vcsr);
      issue(1, 1, 0, $urandom);
      $display("test numeric done");

      for (int t = 0; t < 2; t++)
      begin
         ctrl = t ? 32'h408 : 32'h40C;
         apb(1'b1, vfg_pkg::ADDR_CTRL, ctrl);
         for (i = 1; i <= 6; i++)
            issue(i, 1, 0, $urandom);
         rdc("ctrl", vfg_pkg::ADDR_CTRL, ctrl);
         rdc("vreg", vfg_pkg::ADDR_VDATA, vr[0]);
      end
      @(posedge pclk);
      hw_task_switch <= 1'b1;
      @(posedge pclk);
      hw_task_switch <= 1'b0;
      ctrl[3] = 1;
      rdc("ctrl", vfg_pkg::ADDR_CTRL, ctrl);
      issue(6, 0, 0, 0);
      rdc("ctrl", vfg_pkg::ADDR_CTRL, ctrl);
      $display("test gating done");

      for (i = 0; i < 8; i++)
      begin
         vr[i] = $urandom;
         apb(1'b1, 8'(vfg_pkg::ADDR_VDATA + 4 * i), vr[i]);
      end
      scalar = $urandom;
      apb(1'b1, vfg_pkg::ADDR_SCALAR, scalar);
      vcsr = $urandom & 32'h1F3F;
      apb(1'b1, vfg_pkg::ADDR_VCSR, vcsr);
      issue(4, 0, 0, 0);
      for (i = 0; i < 10; i++)
      begin
         rdc("image", 8'(vfg_pkg::ADDR_IMAGE + 4 * i), img[i]);
         img[i] = (i == 8) ? ($urandom & 32'h1F3F) : $urandom;
         apb(1'b1, 8'(vfg_pkg::ADDR_IMAGE + 4 * i), img[i]);
      end
      issue(5, 0, 0, 0);
      issue(6, 0, 0, 0);
      for (i = 0; i < 8; i++)
         rdc("vreg", 8'(vfg_pkg::ADDR_VDATA + 4 * i), vr[i]);
      rdc("vcsr", vfg_pkg::ADDR_VCSR, vcsr);
      rdc("scalar", vfg_pkg::ADDR_SCALAR, scalar);
      issue(3, 0, 0, $urandom);
      rdc("scalar", vfg_pkg::ADDR_SCALAR, scalar);
      issue(7, 63, 2, $urandom);
      rdc("vreg", 8'(vfg_pkg::ADDR_VDATA + 8), vr[2]);
      $display("test save restore done");
      summarize();
   end

   // whole run needs about six hundred and thirty cycles
   initial
   begin
      repeat (8000) @(posedge pclk);
      $display("watchdog expired");
      err_total++;
      summarize();
   end
endmodule

bind vfg_top vfg_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .ignore_numeric_error_pin(ignore_numeric_error_pin), .hw_task_switch(hw_task_switch),
   .vector_fp_fault(vector_fp_fault), .undefined_opcode_fault(undefined_opcode_fault),
   .device_unavailable_fault(device_unavailable_fault));

`default_nettype wire
